// ===== verilog/rcl_pkg.sv
package rcl_pkg;
   // APB register byte offsets
   localparam logic [7:0] OFF_MANUAL = 8'h00;
   localparam logic [7:0] OFF_CONTROL = 8'h04;
   localparam logic [7:0] OFF_MODE = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam logic [7:0] OFF_INT_STAT = 8'h10;
   localparam logic [7:0] OFF_INT_MASK = 8'h14;
   // Manual control fields and control register soft reset bit
   localparam int MAN_SCLK = 0;
   localparam int MAN_SELECT = 1;
   localparam int MAN_WDATA = 2;
   localparam int MAN_RDATA = 3;
   localparam int MAN_ENABLE = 4;
   localparam int CTL_SOFT_RESET = 0;
   // Mode fields: infrared per channel, auto direction per channel
   localparam int MODE_IR_LSB = 0;
   localparam int MODE_AUTODIR_LSB = 2;
   // Interrupt status fields
   localparam int INT_LOAD_DONE = 0;
   localparam int INT_NO_EEPROM = 1;
   localparam int INT_WAKE = 2;
   localparam int INT_BITS = 3;
   // Loader timing and framing, D3 hot power state code
   localparam int SCLK_DIVIDE = 256;
   localparam int SCLK_HALF = SCLK_DIVIDE / 2;
   localparam logic [7:0] DIV_RISE = 8'(SCLK_HALF);
   localparam logic [7:0] DIV_FALL = 8'h00;
   localparam logic [3:0] SENSE_CYCLES = 4'h8;
   localparam int WORD_COUNT = 8;
   localparam int WORD_BITS = 16;
   localparam int ADDR_BITS = 6;
   localparam int CMD_BITS = 1 + 2 + ADDR_BITS;
   localparam logic [2:0] START_READ = 3'h6;
   localparam logic [4:0] LAST_OUT_BIT = 5'(CMD_BITS - 1);
   localparam logic [4:0] LAST_IN_BIT = 5'(WORD_BITS - 1);
   localparam logic [2:0] LAST_WORD = 3'(WORD_COUNT - 1);
   localparam logic [1:0] PWR_D3_HOT = 2'h3;
   // Word returned when no EEPROM is fitted; value is arbitrary
   localparam logic [15:0] DEFAULT_WORD = 16'hFFFF;

   typedef enum logic [2:0] {
      LD_SENSE = 3'b000,
      LD_SELECT = 3'b001,
      LD_SHIFT_OUT = 3'b010,
      LD_SHIFT_IN = 3'b011,
      LD_DESELECT = 3'b100,
      LD_DONE = 3'b101
   } rcl_load_e;

   typedef struct packed {
      logic enable;
      logic wdata;
      logic select;
      logic sclk;
   } rcl_manual_s;
endpackage : rcl_pkg

// ===== verilog/rcl_id_mem.sv
`timescale 1ns/100ps
module rcl_id_mem (
   // Clock
   input wire logic clk,
   input wire logic clk_en,
   // Write port
   input wire logic wr_en,
   input wire logic [2:0] wr_addr,
   input wire logic [15:0] wr_data,
   // Read port
   input wire logic rd_en,
   input wire logic [2:0] rd_addr,
   output logic [15:0] rd_data
);
   logic [15:0] mem [0:rcl_pkg::WORD_COUNT-1];

   always_ff @(posedge clk) begin
      if (clk_en && wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (clk_en && rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule : rcl_id_mem

// ===== verilog/rcl_top.sv
// What this block does
// (R1) Load clock is bus clock divided by 256
// (R2) Software toggles serial clock outside the load
// (R3) Software drives select line manually
// (R4) Sense select pull-up; load only if present
// (R5) Shift commands out in 16-bit word format
// (R6) Capture read data; software can read it
// (R7) Sample infrared strap at every reset kind
// (R8) Infrared strap sets channel modem bit 6
// (R9) High half-duplex strap sets auto direction
// (R10) Software may overwrite auto direction bits
// (R11) D3 hot wake asserts open-drain event
// (R12) Automatic load reads eight 16-bit words
// (R13) Select, start, opcode, address, sixteen data bits
// (R14) Hold configuration reads until load completes
`timescale 1ns/100ps
module rcl_top (
   // Clock and reset
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic CLK_EN,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // EEPROM pins
   output logic EEPROM_SERIAL_CLOCK,
   output logic EEPROM_SELECT_O,
   output logic EEPROM_SELECT_OE,
   input wire logic EEPROM_SELECT_I,
   output logic EEPROM_WRITE_DATA,
   input wire logic EEPROM_READ_DATA,
   // Strap pins
   input wire logic INFRARED_STRAP,
   input wire logic HALF_DUPLEX_STRAP_N,
   // Channel mode outputs
   output logic [1:0] IR_MODE,
   output logic [1:0] AUTO_DIR_MODE,
   // Identification word port
   input wire logic CFG_REQ,
   input wire logic [2:0] CFG_ADDR,
   output logic CFG_ACK,
   output logic [15:0] CFG_DATA,
   output logic LOAD_DONE,
   // Power management
   input wire logic [1:0] POWER_STATE,
   input wire logic POWER_EVENT_ENABLE,
   input wire logic [1:0] RX_NEW_CHAR,
   input wire logic [1:0] MODEM_CHANGE,
   output logic POWER_EVENT_N_O,
   output logic POWER_EVENT_N_OE,
   // Interrupt
   output logic IRQ
);
   localparam int NSYNC = 4;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr == off);
   endfunction : hit

   // Pin synchronisers: read data, select sense, infrared, half duplex
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] s1;
   logic [NSYNC-1:0] s2;
   logic [NSYNC-1:0] s3;
   logic [NSYNC-1:0] filt;
   assign pin_raw = {HALF_DUPLEX_STRAP_N, INFRARED_STRAP, EEPROM_SELECT_I, EEPROM_READ_DATA};

   genvar g;
   generate
      for (g = 0; g < NSYNC; g++) begin : g_sync
         always_ff @(posedge MCLK) begin
            if (!NRST) begin
               s1[g] <= 1'b0;
               s2[g] <= 1'b0;
               s3[g] <= 1'b0;
               filt[g] <= 1'b0;
            end else if (CLK_EN) begin
               s1[g] <= pin_raw[g];
               s2[g] <= s1[g];
               s3[g] <= s2[g];
               if (s2[g] == s3[g]) begin
                  filt[g] <= s3[g];
               end
            end
         end
      end
   endgenerate

   logic rd_filt;
   logic sel_filt;
   logic ir_filt;
   logic hd_filt;
   assign rd_filt = filt[0];
   assign sel_filt = filt[1];
   assign ir_filt = filt[2];
   assign hd_filt = filt[3];

   // APB decode
   logic apb_acc;
   logic apb_wr;
   logic apb_rd;
   logic mapped;
   assign apb_acc = PSEL && PENABLE && PREADY;
   assign apb_wr = apb_acc && PWRITE;
   assign apb_rd = apb_acc && !PWRITE;
   assign mapped = hit(PADDR, rcl_pkg::OFF_MANUAL) || hit(PADDR, rcl_pkg::OFF_CONTROL)
      || hit(PADDR, rcl_pkg::OFF_MODE) || hit(PADDR, rcl_pkg::OFF_STATUS)
      || hit(PADDR, rcl_pkg::OFF_INT_STAT) || hit(PADDR, rcl_pkg::OFF_INT_MASK);

   logic soft_reset;
   assign soft_reset = CLK_EN && apb_wr && hit(PADDR, rcl_pkg::OFF_CONTROL) && PWDATA[rcl_pkg::CTL_SOFT_RESET];

   // Loader state
   rcl_pkg::rcl_load_e ld_state;
   logic [7:0] div;
   logic [3:0] sense_cnt;
   logic [4:0] bit_cnt;
   logic [2:0] word;
   logic [8:0] cmd;
   logic [15:0] shreg;
   logic present;
   logic ld_sclk;
   logic ld_cs;
   logic ld_di;
   logic mem_we;
   logic tick_rise;
   logic tick_fall;
   logic sense_end;
   logic loading;
   assign tick_rise = (div == rcl_pkg::DIV_RISE);
   assign tick_fall = (div == rcl_pkg::DIV_FALL);
   assign sense_end = (ld_state == rcl_pkg::LD_SENSE) && (sense_cnt == rcl_pkg::SENSE_CYCLES);
   assign loading = (ld_state != rcl_pkg::LD_DONE) && (ld_state != rcl_pkg::LD_SENSE);

   always_ff @(posedge MCLK) begin
      if (!NRST || soft_reset) begin
         div <= 8'h00;
      end else if (CLK_EN) begin
         div <= div + 8'h01; // R1
      end
   end

   always_ff @(posedge MCLK) begin
      if (!NRST || soft_reset) begin
         sense_cnt <= 4'h0;
      end else if (CLK_EN && ld_state == rcl_pkg::LD_SENSE && !sense_end) begin
         sense_cnt <= sense_cnt + 4'h1;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!NRST || soft_reset) begin
         ld_state <= rcl_pkg::LD_SENSE;
         present <= 1'b0;
         bit_cnt <= 5'h00;
         word <= 3'h0;
         cmd <= 9'h000;
         shreg <= 16'h0000;
         ld_sclk <= 1'b0;
         ld_cs <= 1'b0;
         ld_di <= 1'b0;
         mem_we <= 1'b0;
      end else if (CLK_EN) begin
         mem_we <= 1'b0;
         if (loading) begin
            ld_sclk <= (div >= rcl_pkg::DIV_RISE); // R1
         end
         unique case (ld_state)
            rcl_pkg::LD_SENSE: begin
               if (sense_end) begin
                  present <= sel_filt; // R4
                  ld_state <= sel_filt ? rcl_pkg::LD_SELECT : rcl_pkg::LD_DONE; // R4
               end
            end
            rcl_pkg::LD_SELECT: begin
               if (tick_fall) begin
                  ld_cs <= 1'b1; // R13
                  ld_di <= rcl_pkg::START_READ[2]; // R13
                  cmd <= {rcl_pkg::START_READ[1:0], 3'h0, word, 1'b0}; // R5
                  bit_cnt <= 5'h00;
                  ld_state <= rcl_pkg::LD_SHIFT_OUT;
               end
            end
            rcl_pkg::LD_SHIFT_OUT: begin
               if (tick_fall) begin
                  // Last bit out is the zero pad ahead of the data phase
                  ld_di <= cmd[8]; // R5
                  cmd <= {cmd[7:0], 1'b0};
                  if (bit_cnt == rcl_pkg::LAST_OUT_BIT) begin
                     bit_cnt <= 5'h00;
                     ld_state <= rcl_pkg::LD_SHIFT_IN;
                  end else begin
                     bit_cnt <= bit_cnt + 5'h01;
                  end
               end
            end
            rcl_pkg::LD_SHIFT_IN: begin
               if (tick_rise) begin
                  shreg <= {shreg[14:0], rd_filt}; // R6
                  bit_cnt <= bit_cnt + 5'h01;
                  if (bit_cnt == rcl_pkg::LAST_IN_BIT) begin
                     mem_we <= 1'b1; // R12
                     ld_state <= rcl_pkg::LD_DESELECT;
                  end
               end
            end
            rcl_pkg::LD_DESELECT: begin
               if (tick_fall) begin
                  ld_cs <= 1'b0; // R13
                  ld_sclk <= 1'b0;
                  word <= word + 3'h1;
                  ld_state <= (word == rcl_pkg::LAST_WORD) ? rcl_pkg::LD_DONE : rcl_pkg::LD_SELECT; // R12
               end
            end
            rcl_pkg::LD_DONE: begin
               ld_sclk <= 1'b0;
            end
            default: begin
               ld_state <= rcl_pkg::LD_DONE;
            end
         endcase
      end
   end

   // Manual control register
   rcl_pkg::rcl_manual_s man;
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         man <= '0;
      end else if (CLK_EN && apb_wr && hit(PADDR, rcl_pkg::OFF_MANUAL)) begin
         man.sclk <= PWDATA[rcl_pkg::MAN_SCLK]; // R2
         man.select <= PWDATA[rcl_pkg::MAN_SELECT]; // R3
         man.wdata <= PWDATA[rcl_pkg::MAN_WDATA];
         man.enable <= PWDATA[rcl_pkg::MAN_ENABLE];
      end
   end

   // EEPROM pin drivers; select released while sensing the pull-up
   logic manual_active;
   assign manual_active = !loading && man.enable && ld_state != rcl_pkg::LD_SENSE;
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         EEPROM_SERIAL_CLOCK <= 1'b0;
         EEPROM_SELECT_O <= 1'b0;
         EEPROM_SELECT_OE <= 1'b0;
         EEPROM_WRITE_DATA <= 1'b0;
      end else if (CLK_EN) begin
         EEPROM_SERIAL_CLOCK <= manual_active ? man.sclk : ld_sclk; // R2
         EEPROM_SELECT_O <= manual_active ? man.select : ld_cs; // R3
         EEPROM_SELECT_OE <= (ld_state != rcl_pkg::LD_SENSE); // R4
         EEPROM_WRITE_DATA <= manual_active ? man.wdata : ld_di; // R5
      end
   end

   // Channel modes: strap values at reset, software owns them afterwards
   logic [3:0] mode;
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         mode <= 4'h0;
      end else if (CLK_EN) begin
         if (sense_end) begin
            mode[rcl_pkg::MODE_IR_LSB +: 2] <= {2{ir_filt}}; // R7 R8
            mode[rcl_pkg::MODE_AUTODIR_LSB +: 2] <= {2{hd_filt}}; // R9
         end else if (apb_wr && hit(PADDR, rcl_pkg::OFF_MODE)) begin
            mode <= PWDATA[3:0]; // R8 R10
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         IR_MODE <= 2'h0;
         AUTO_DIR_MODE <= 2'h0;
      end else if (CLK_EN) begin
         IR_MODE <= mode[rcl_pkg::MODE_IR_LSB +: 2];
         AUTO_DIR_MODE <= mode[rcl_pkg::MODE_AUTODIR_LSB +: 2];
      end
   end

   // Identification word store and configuration read port
   logic [15:0] mem_rd;
   logic cfg_pend;
   logic cfg_issue;
   assign cfg_issue = CFG_REQ && LOAD_DONE && !cfg_pend && !CFG_ACK; // R14

   rcl_id_mem u_mem (
      .clk(MCLK),
      .clk_en(CLK_EN),
      .wr_en(mem_we),
      .wr_addr(word),
      .wr_data(shreg),
      .rd_en(cfg_issue),
      .rd_addr(CFG_ADDR),
      .rd_data(mem_rd)
   );

   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         cfg_pend <= 1'b0;
         CFG_ACK <= 1'b0;
         CFG_DATA <= 16'h0000;
         LOAD_DONE <= 1'b0;
      end else if (CLK_EN) begin
         LOAD_DONE <= (ld_state == rcl_pkg::LD_DONE) && !soft_reset;
         cfg_pend <= cfg_issue;
         CFG_ACK <= cfg_pend;
         if (cfg_pend) begin
            CFG_DATA <= present ? mem_rd : rcl_pkg::DEFAULT_WORD;
         end
      end
   end

   // Wake event
   logic wake_arm;
   logic wake_event;
   assign wake_arm = (POWER_STATE == rcl_pkg::PWR_D3_HOT) && POWER_EVENT_ENABLE;
   assign wake_event = wake_arm && ((|RX_NEW_CHAR) || (|MODEM_CHANGE));
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         POWER_EVENT_N_O <= 1'b0;
         POWER_EVENT_N_OE <= 1'b0;
      end else if (CLK_EN) begin
         POWER_EVENT_N_O <= 1'b0;
         if (!wake_arm) begin
            POWER_EVENT_N_OE <= 1'b0;
         end else if (wake_event) begin
            POWER_EVENT_N_OE <= 1'b1; // R11
         end
      end
   end

   // Interrupt status and mask
   logic [rcl_pkg::INT_BITS-1:0] int_stat;
   logic [rcl_pkg::INT_BITS-1:0] int_mask;
   logic [rcl_pkg::INT_BITS-1:0] int_set;
   logic [rcl_pkg::INT_BITS-1:0] int_clr;
   logic ld_end;
   assign ld_end = (ld_state == rcl_pkg::LD_DONE) && !LOAD_DONE && !soft_reset;
   assign int_set = {wake_event, ld_end && !present, ld_end};
   assign int_clr = (apb_wr && hit(PADDR, rcl_pkg::OFF_INT_STAT)) ? PWDATA[rcl_pkg::INT_BITS-1:0] : '0;

   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         int_stat <= '0;
         int_mask <= '0;
         IRQ <= 1'b0;
      end else if (CLK_EN) begin
         int_stat <= (int_stat & ~int_clr) | int_set;
         if (apb_wr && hit(PADDR, rcl_pkg::OFF_INT_MASK)) begin
            int_mask <= PWDATA[rcl_pkg::INT_BITS-1:0];
         end
         IRQ <= |(int_stat & int_mask);
      end
   end

   // APB answer: one wait state, then the access completes
   logic [31:0] rdata;
   always_comb begin
      rdata = 32'h0000_0000;
      if (hit(PADDR, rcl_pkg::OFF_MANUAL)) begin
         rdata[rcl_pkg::MAN_SCLK] = man.sclk;
         rdata[rcl_pkg::MAN_SELECT] = man.select;
         rdata[rcl_pkg::MAN_WDATA] = man.wdata;
         rdata[rcl_pkg::MAN_RDATA] = rd_filt; // R6
         rdata[rcl_pkg::MAN_ENABLE] = man.enable;
      end else if (hit(PADDR, rcl_pkg::OFF_MODE)) begin
         rdata[3:0] = mode;
      end else if (hit(PADDR, rcl_pkg::OFF_STATUS)) begin
         rdata[4:0] = {hd_filt, ir_filt, present, LOAD_DONE, loading};
      end else if (hit(PADDR, rcl_pkg::OFF_INT_STAT)) begin
         rdata[rcl_pkg::INT_BITS-1:0] = int_stat;
      end else if (hit(PADDR, rcl_pkg::OFF_INT_MASK)) begin
         rdata[rcl_pkg::INT_BITS-1:0] = int_mask;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h0000_0000;
      end else if (CLK_EN) begin
         PREADY <= PSEL && PENABLE && !PREADY;
         PSLVERR <= PSEL && PENABLE && !PREADY && !mapped;
         if (PSEL && PENABLE && !PREADY && !PWRITE) begin
            PRDATA <= rdata;
         end
      end
   end

   // Helper: words written in the current load
   logic [3:0] words_written;
   always_ff @(posedge MCLK) begin
      if (!NRST || soft_reset) begin
         words_written <= 4'h0;
      end else if (CLK_EN && mem_we) begin
         words_written <= words_written + 4'h1;
      end
   end

   sequence s_load_rise;
      loading && CLK_EN && tick_rise;
   endsequence

   sequence s_cmd_start;
      $rose(ld_cs) ##1 EEPROM_SELECT_O && EEPROM_WRITE_DATA;
   endsequence

   property p_div_half;
      @(posedge MCLK) disable iff (!NRST || !CLK_EN || soft_reset)
      s_load_rise |=> ld_sclk ##128 !ld_sclk || !loading;
   endproperty
   a_div_half: assert property (p_div_half) else $error("load clock half period wrong"); // R1

   property p_manual_clk;
      @(posedge MCLK) disable iff (!NRST || !CLK_EN)
      manual_active |=> EEPROM_SERIAL_CLOCK == $past(man.sclk);
   endproperty
   a_manual_clk: assert property (p_manual_clk) else $error("manual clock not followed"); // R2

   property p_manual_sel;
      @(posedge MCLK) disable iff (!NRST || !CLK_EN)
      manual_active |=> EEPROM_SELECT_O == $past(man.select) && EEPROM_SELECT_OE;
   endproperty
   a_manual_sel: assert property (p_manual_sel) else $error("manual select not followed"); // R3

   property p_sense;
      @(posedge MCLK) disable iff (!NRST || !CLK_EN)
      sense_end && !sel_filt |=> ld_state == rcl_pkg::LD_DONE && !present;
   endproperty
   a_sense: assert property (p_sense) else $error("absent eeprom still loaded"); // R4

   property p_start_bit;
      @(posedge MCLK) disable iff (!NRST || !CLK_EN || soft_reset || man.enable)
      $rose(ld_cs) |-> s_cmd_start;
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("start bit missing"); // R5 R13

   property p_capture;
      @(posedge MCLK) disable iff (!NRST || !CLK_EN || soft_reset)
      ld_state == rcl_pkg::LD_SHIFT_IN && tick_rise |=> shreg[0] == $past(rd_filt);
   endproperty
   a_capture: assert property (p_capture) else $error("read data not captured"); // R6

   property p_straps;
      @(posedge MCLK) disable iff (!NRST || !CLK_EN)
      sense_end |=> ##1 IR_MODE == {2{$past(ir_filt, 2)}} && AUTO_DIR_MODE == {2{$past(hd_filt, 2)}};
   endproperty
   a_straps: assert property (p_straps) else $error("strap not copied"); // R7 R8 R9

   property p_mode_write;
      @(posedge MCLK) disable iff (!NRST || !CLK_EN)
      apb_wr && hit(PADDR, rcl_pkg::OFF_MODE) && !sense_end |=> ##1 AUTO_DIR_MODE == $past(PWDATA[3:2], 2);
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("mode write lost"); // R10

   property p_wake;
      @(posedge MCLK) disable iff (!NRST || !CLK_EN)
      wake_event |=> POWER_EVENT_N_OE && !POWER_EVENT_N_O;
   endproperty
   a_wake: assert property (p_wake) else $error("wake event not driven"); // R11

   property p_eight_words;
      @(posedge MCLK) disable iff (!NRST || !CLK_EN || soft_reset)
      ld_end && present |-> words_written == 4'(rcl_pkg::WORD_COUNT);
   endproperty
   a_eight_words: assert property (p_eight_words) else $error("word count wrong"); // R12

   property p_hold_off;
      @(posedge MCLK) disable iff (!NRST || !CLK_EN)
      CFG_REQ && !LOAD_DONE && !cfg_pend |=> !cfg_pend && !CFG_ACK;
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("config answered before load"); // R14
endmodule : rcl_top

// ===== dv/rcl_eeprom_model.sv
`timescale 1ns/100ps
module rcl_eeprom_model (
   // Presence and pins
   input wire logic present,
   input wire logic sclk,
   input wire logic sel_o,
   input wire logic sel_oe,
   input wire logic di,
   output logic sel_i,
   output logic do_pin,
   // Observed traffic
   output int words_read,
   output int bad_cmds
);
   logic cs;
   int cnt = 0;
   logic [8:0] cmd = '0;
   logic [15:0] word = '0;
   initial begin
      do_pin = 1'b0;
      words_read = 0;
      bad_cmds = 0;
   end
   assign cs = sel_oe & sel_o & present;
   // Pull-up only when the part is fitted
   assign sel_i = sel_oe ? sel_o : present;
   always @(negedge cs) begin
      cnt = 0;
      do_pin = ~do_pin;
   end
   always @(posedge sclk) begin
      if (cs) begin
         if (cnt < 9) cmd = {cmd[7:0], di};
         cnt = cnt + 1;
         if (cnt == 9) begin
            if (cmd[8:6] !== 3'b110 || cmd[5:3] !== 3'b000) bad_cmds++;
            word = {1'b0, cmd[2:0], 4'hA, 1'b1, ~cmd[2:0], 4'h5};
            words_read++;
         end
      end
   end
   always @(negedge sclk) begin
      if (cs && cnt >= 9 && cnt < 25) do_pin = word[24 - cnt];
   end
endmodule : rcl_eeprom_model

// ===== dv/reset_config_loader_and_wake_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; $display("[ERR] %0t mismatch", $time); end end
module reset_config_loader_and_wake_tb;
   logic mclk, nrst, psel, penable, pwrite, pready, pslverr, sclk, sel_o, sel_oe, sel_i, wd, rd;
   logic ir_s, hd_s, cfg_req, cfg_ack, load_done, pme_en, pe_o, pe_oe, irq, present;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [1:0] ir_m, ad_m, pstate, rxn, mchg;
   logic [2:0] cfg_addr;
   logic [15:0] cfg_data, w;
   logic e, ce;
   int words_read, bad_cmds, err_count = 0, checks_done = 0, cyc = 0, a, b;
   wire logic pe_pin = pe_oe ? pe_o : 1'b1;
   rcl_top dut (.MCLK(mclk), .NRST(nrst), .CLK_EN(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .EEPROM_SERIAL_CLOCK(sclk), .EEPROM_SELECT_O(sel_o), .EEPROM_SELECT_OE(sel_oe), .EEPROM_SELECT_I(sel_i),
      .EEPROM_WRITE_DATA(wd), .EEPROM_READ_DATA(rd), .INFRARED_STRAP(ir_s), .HALF_DUPLEX_STRAP_N(hd_s),
      .IR_MODE(ir_m), .AUTO_DIR_MODE(ad_m), .CFG_REQ(cfg_req), .CFG_ADDR(cfg_addr), .CFG_ACK(cfg_ack),
      .CFG_DATA(cfg_data), .LOAD_DONE(load_done), .POWER_STATE(pstate), .POWER_EVENT_ENABLE(pme_en),
      .RX_NEW_CHAR(rxn), .MODEM_CHANGE(mchg), .POWER_EVENT_N_O(pe_o), .POWER_EVENT_N_OE(pe_oe), .IRQ(irq));
   rcl_eeprom_model eeprom (.present(present), .sclk(sclk), .sel_o(sel_o), .sel_oe(sel_oe), .di(wd),
      .sel_i(sel_i), .do_pin(rd), .words_read(words_read), .bad_cmds(bad_cmds));
   task wrap_up;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : wrap_up
   task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask : apb
   task cfg(input logic [2:0] ad);
      @(posedge mclk);
      cfg_addr <= ad;
      cfg_req <= 1'b1;
      do @(posedge mclk); while (cfg_ack !== 1'b1);
      w = cfg_data;
      cfg_req <= 1'b0;
   endtask : cfg
   task lvl(input logic v, output int n);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (sclk !== v);
   endtask : lvl
   task pulse(input logic [3:0] ev);
      @(posedge mclk);
      {rxn, mchg} <= ev;
      @(posedge mclk);
      {rxn, mchg} <= 4'h0;
      repeat (3) @(posedge mclk);
   endtask : pulse
   task t_absent;
      `CHK(sel_oe, 1'b0)
      while (load_done !== 1'b1) @(posedge mclk);
      `CHK(ir_m, 2'b11)
      `CHK(ad_m, 2'b11)
      apb(1'b0, rcl_pkg::OFF_STATUS, 32'h0);
      `CHK(q[2], 1'b0)
      apb(1'b0, rcl_pkg::OFF_INT_STAT, 32'h0);
      `CHK(q[1], 1'b1)
      cfg(3'h3);
      `CHK(w, 16'hFFFF)
      $display("absent done");
   endtask : t_absent
   task t_mode;
      apb(1'b1, rcl_pkg::OFF_MODE, 32'h4);
      `CHK(ir_m, 2'b00)
      `CHK(ad_m, 2'b01)
      apb(1'b0, rcl_pkg::OFF_MODE, 32'h0);
      `CHK(q, 32'h4)
      $display("mode done");
   endtask : t_mode
   task t_manual;
      apb(1'b1, rcl_pkg::OFF_MANUAL, 32'h17);
      `CHK({sclk, sel_o, sel_oe, wd}, 4'hF)
      apb(1'b1, rcl_pkg::OFF_MANUAL, 32'h10);
      `CHK({sclk, sel_o}, 2'b00)
      `CHK(sel_oe, 1'b1)
      apb(1'b0, rcl_pkg::OFF_MANUAL, 32'h0);
      `CHK(q[3], rd)
      apb(1'b1, rcl_pkg::OFF_MANUAL, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      `CHK({e, q}, {1'b1, 32'h0})
      $display("manual done");
   endtask : t_manual
   task t_wake;
      apb(1'b1, rcl_pkg::OFF_INT_MASK, 32'h4);
      pstate <= 2'h3;
      pme_en <= 1'b1;
      pulse(4'h8);
      `CHK({pe_pin, irq}, 2'b01)
      apb(1'b1, rcl_pkg::OFF_INT_STAT, 32'h4);
      `CHK({pe_pin, irq}, 2'b00)
      pstate <= 2'h2;
      repeat (3) @(posedge mclk);
      `CHK(pe_pin, 1'b1)
      pulse(4'h1);
      `CHK(pe_pin, 1'b1)
      $display("wake done");
   endtask : t_wake
   task t_load;
      ir_s <= 1'b0;
      hd_s <= 1'b0;
      present <= 1'b1;
      apb(1'b1, rcl_pkg::OFF_CONTROL, 32'h1);
      `CHK(load_done, 1'b0)
      cfg_req <= 1'b1;
      a = 0;
      repeat (40) begin
         @(posedge mclk);
         if (cfg_ack !== 1'b0) a++;
      end
      `CHK(a, 0)
      cfg_req <= 1'b0;
      lvl(1'b1, a);
      lvl(1'b0, a);
      lvl(1'b1, b);
      `CHK(a + b, 256)
      a = 0;
      ce <= 1'b0;
      repeat (300) begin
         @(posedge mclk);
         if (sclk !== 1'b1) a++;
      end
      ce <= 1'b1;
      `CHK(a, 0)
      while (load_done !== 1'b1) @(posedge mclk);
      `CHK(words_read, 8)
      `CHK(bad_cmds, 0)
      `CHK({ir_m, ad_m}, 4'h0)
      for (int i = 0; i < 8; i++) begin
         cfg(3'(i));
         `CHK(w, {1'b0, 3'(i), 4'hA, 1'b1, ~3'(i), 4'h5})
      end
      apb(1'b0, rcl_pkg::OFF_STATUS, 32'h0);
      `CHK(q[2], 1'b1)
      $display("load done");
   endtask : t_load
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 90000) begin
         err_count++;
         wrap_up();
      end
   end
   initial begin
      {nrst, psel, penable, pwrite, cfg_req, pme_en, present} = '0;
      {paddr, pwdata, pstate, rxn, mchg, cfg_addr} = '0;
      ce = 1'b1;
      ir_s = 1'b1;
      hd_s = 1'b1;
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      #1;
      t_absent();
      t_mode();
      t_manual();
      t_wake();
      t_load();
      wrap_up();
   end
endmodule : reset_config_loader_and_wake_tb
